// file: shared/cis_pkg.sv
// constants and types for the cipher input staging block
package cis_pkg;
  localparam logic [7:0] ADDR_BLOCK_IN = 8'heb;
  localparam logic [7:0] ADDR_XOR_IN = 8'hec;
  localparam logic [7:0] ADDR_KEY_IN = 8'hed;
  localparam logic [7:0] ADDR_BLOCK_CFG = 8'he9;
  localparam logic [7:0] ADDR_DATA_CFG = 8'hea;
  localparam logic [3:0] SFR_PAGE = 4'h2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int BCFG_DONE = 5;
  localparam int BCFG_BUSY = 4;
  localparam int BCFG_EN = 3;
  localparam int BCFG_ENC = 2;
  localparam int DCFG_XOR_EN = 0;
  localparam logic [1:0] KEY_LEN_SEL_128 = 2'h0;
  localparam logic [1:0] KEY_LEN_SEL_192 = 2'h1;
  localparam logic [1:0] KEY_LEN_SEL_256 = 2'h2;
  localparam logic [5:0] KEY_BYTES_128 = 6'h10;
  localparam logic [5:0] KEY_BYTES_192 = 6'h18;
  localparam logic [5:0] KEY_BYTES_256 = 6'h20;
  localparam logic [4:0] BLOCK_BYTES = 5'h10;
  localparam logic [8:0] CYC_128 = 9'd218;
  localparam logic [8:0] CYC_192 = 9'd274;
  localparam logic [8:0] CYC_256 = 9'd298;
  typedef enum logic [2:0] {
    CIS_IDLE = 3'b001,
    CIS_LOAD = 3'b010,
    CIS_RUN = 3'b100
  } cis_state_t;
endpackage

// file: rtl/cis_sfr_byte.sv
// one 8-bit read/write input register with write strobe
`timescale 1ns/1ps
module cis_sfr_byte (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] q_o
);
  logic [7:0] q_r;
  logic [7:0] q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (wr_i) begin
      q_nxt = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= cis_pkg::RESET_BYTE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule // cis_sfr_byte

// file: rtl/cis_top.sv
// byte-wide input staging for the block cipher core
`timescale 1ns/1ps
module cis_top (
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic [3:0] SFR_PAGE_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  output logic [127:0] CIPHER_DATA_O,
  output logic [255:0] CIPHER_KEY_O,
  output logic [127:0] CIPHER_XOR_O,
  output logic CIPHER_ENC_O,
  output logic CIPHER_START_O,
  output logic CIPHER_BUSY_O,
  output logic CIPHER_DONE_O
);
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  logic page_hit;
  logic wr_blk, wr_xor, wr_key, wr_bcfg, wr_dcfg;
  logic [7:0] blk_q, xor_q, key_q;
  assign page_hit = (SFR_PAGE_I == cis_pkg::SFR_PAGE);
  assign wr_blk = SFR_WR_I && page_hit && (SFR_ADDR_I == cis_pkg::ADDR_BLOCK_IN);
  assign wr_xor = SFR_WR_I && page_hit && (SFR_ADDR_I == cis_pkg::ADDR_XOR_IN);
  assign wr_key = SFR_WR_I && page_hit && (SFR_ADDR_I == cis_pkg::ADDR_KEY_IN);
  assign wr_bcfg = SFR_WR_I && page_hit && (SFR_ADDR_I == cis_pkg::ADDR_BLOCK_CFG);
  assign wr_dcfg = SFR_WR_I && page_hit && (SFR_ADDR_I == cis_pkg::ADDR_DATA_CFG);

  cis_sfr_byte u_blk (.clk_i(REF_CLK_I), .rst_n_i(rst_n_r), .wr_i(wr_blk), .wdata_i(SFR_WDATA_I), .q_o(blk_q));
  cis_sfr_byte u_xor (.clk_i(REF_CLK_I), .rst_n_i(rst_n_r), .wr_i(wr_xor), .wdata_i(SFR_WDATA_I), .q_o(xor_q));
  cis_sfr_byte u_key (.clk_i(REF_CLK_I), .rst_n_i(rst_n_r), .wr_i(wr_key), .wdata_i(SFR_WDATA_I), .q_o(key_q));

  logic [1:0] key_len_sel_r, key_len_sel_nxt;
  logic enc_r, enc_nxt;
  logic en_r, en_nxt;
  logic done_r, done_nxt;
  logic xor_en_r, xor_en_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic [8:0] cnt_r, cnt_nxt;
  logic [127:0] data_buf_r, data_buf_nxt;
  logic [127:0] xbuf_r, xbuf_nxt;
  logic [255:0] key_buf_r, key_buf_nxt;
  logic start_r, start_nxt;
  cis_pkg::cis_state_t st_r, st_nxt;
  logic [5:0] key_len;
  logic [8:0] run_cyc;
  logic [127:0] cin_r, cin_nxt;
  logic busy;

  always_comb begin
    key_len = cis_pkg::KEY_BYTES_128;
    run_cyc = cis_pkg::CYC_128;
    if (key_len_sel_r == cis_pkg::KEY_LEN_SEL_192) begin
      key_len = cis_pkg::KEY_BYTES_192;
      run_cyc = cis_pkg::CYC_192;
    end else if (key_len_sel_r == cis_pkg::KEY_LEN_SEL_256) begin
      key_len = cis_pkg::KEY_BYTES_256;
      run_cyc = cis_pkg::CYC_256;
    end
  end

  always_comb begin
    cin_nxt = data_buf_r;
    if (xor_en_r) begin
      cin_nxt = data_buf_r ^ xbuf_r;
    end
  end
  assign busy = (st_r == cis_pkg::CIS_RUN);

  always_comb begin
    key_len_sel_nxt = key_len_sel_r;
    enc_nxt = enc_r;
    en_nxt = en_r;
    done_nxt = done_r;
    xor_en_nxt = xor_en_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    data_buf_nxt = data_buf_r;
    xbuf_nxt = xbuf_r;
    key_buf_nxt = key_buf_r;
    start_nxt = 1'b0;
    st_nxt = st_r;
    if (wr_bcfg) begin
      key_len_sel_nxt = SFR_WDATA_I[1:0];
      enc_nxt = SFR_WDATA_I[cis_pkg::BCFG_ENC];
      en_nxt = SFR_WDATA_I[cis_pkg::BCFG_EN];
      done_nxt = SFR_WDATA_I[cis_pkg::BCFG_DONE];
    end
    if (wr_dcfg) begin
      xor_en_nxt = SFR_WDATA_I[cis_pkg::DCFG_XOR_EN];
    end
    if (wr_blk && idx_r < 6'(cis_pkg::BLOCK_BYTES)) begin
      data_buf_nxt[idx_r[3:0]*8 +: 8] = SFR_WDATA_I;
    end
    if (wr_xor && idx_r < 6'(cis_pkg::BLOCK_BYTES)) begin
      xbuf_nxt[idx_r[3:0]*8 +: 8] = SFR_WDATA_I;
    end
    unique case (st_r)
      cis_pkg::CIS_IDLE: begin
        idx_nxt = '0;
        if (en_r && !busy) begin
          st_nxt = cis_pkg::CIS_LOAD;
        end
      end
      cis_pkg::CIS_LOAD: begin
        if (wr_key) begin
          key_buf_nxt[idx_r[4:0]*8 +: 8] = SFR_WDATA_I;
          idx_nxt = idx_r + 6'h01;
          if (idx_r + 6'h01 == key_len) begin
            st_nxt = cis_pkg::CIS_RUN;
            cnt_nxt = run_cyc;
            start_nxt = 1'b1;
          end
        end
      end
      cis_pkg::CIS_RUN: begin
        cnt_nxt = cnt_r - 9'h001;
        if (cnt_r == 9'h001) begin
          done_nxt = 1'b1;
          idx_nxt = '0;
          st_nxt = cis_pkg::CIS_LOAD;
        end
      end
      default: st_nxt = cis_pkg::CIS_IDLE;
    endcase
    if (!en_nxt) begin
      st_nxt = cis_pkg::CIS_IDLE;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      key_len_sel_r <= cis_pkg::KEY_LEN_SEL_128;
      cin_r <= '0;
      enc_r <= 1'b0;
      en_r <= 1'b0;
      done_r <= 1'b0;
      xor_en_r <= 1'b0;
      idx_r <= '0;
      cnt_r <= '0;
      data_buf_r <= '0;
      xbuf_r <= '0;
      key_buf_r <= '0;
      start_r <= 1'b0;
      st_r <= cis_pkg::CIS_IDLE;
    end else begin
      key_len_sel_r <= key_len_sel_nxt;
      cin_r <= cin_nxt;
      enc_r <= enc_nxt;
      en_r <= en_nxt;
      done_r <= done_nxt;
      xor_en_r <= xor_en_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      data_buf_r <= data_buf_nxt;
      xbuf_r <= xbuf_nxt;
      key_buf_r <= key_buf_nxt;
      start_r <= start_nxt;
      st_r <= st_nxt;
    end
  end

  logic [7:0] rdata_r, rdata_nxt;
  always_comb begin
    rdata_nxt = 8'h00;
    if (SFR_RD_I && page_hit) begin
      unique case (SFR_ADDR_I)
        cis_pkg::ADDR_BLOCK_IN: rdata_nxt = blk_q;
        cis_pkg::ADDR_XOR_IN: rdata_nxt = xor_q;
        cis_pkg::ADDR_KEY_IN: rdata_nxt = key_q;
        cis_pkg::ADDR_BLOCK_CFG: rdata_nxt = {2'h0, done_r, busy, en_r, enc_r, key_len_sel_r};
        cis_pkg::ADDR_DATA_CFG: rdata_nxt = {7'h00, xor_en_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign SFR_RDATA_O = rdata_r;
  assign CIPHER_DATA_O = cin_r;
  assign CIPHER_KEY_O = key_buf_r;
  assign CIPHER_XOR_O = xbuf_r;
  assign CIPHER_ENC_O = enc_r;
  assign CIPHER_START_O = start_r;
  assign CIPHER_BUSY_O = busy;
  assign CIPHER_DONE_O = done_r;
endmodule // cis_top

// file: verif/cis_top_sva.sv
// port assertions for the cipher input staging block
`timescale 1ns/1ps
module cis_top_chk (
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic [3:0] SFR_PAGE_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic CIPHER_START_O,
  input wire logic CIPHER_BUSY_O,
  input wire logic CIPHER_DONE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  property p_rd_idle; !$past(SFR_RD_I) |-> SFR_RDATA_O == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_rd_unmap;
    SFR_RD_I && (SFR_PAGE_I != 4'h2 || SFR_ADDR_I < 8'he9 || SFR_ADDR_I > 8'hed) |=> SFR_RDATA_O == 8'h00;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
  property p_done_hold; $fell(CIPHER_DONE_O) |-> $past(SFR_WR_I && SFR_PAGE_I == 4'h2 && SFR_ADDR_I == 8'he9); endproperty
  a_done_hold: assert property (p_done_hold) else $error("done cleared by itself");
  property p_done_set; $rose(CIPHER_DONE_O) |-> $past(CIPHER_BUSY_O); endproperty
  a_done_set: assert property (p_done_set) else $error("done without run");
  property p_start_pulse; CIPHER_START_O |=> !CIPHER_START_O; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_cause; CIPHER_START_O |-> $past(SFR_WR_I) || $past(SFR_WR_I, 2); endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without write");
  property p_start_busy; CIPHER_START_O |-> ##[0:1] CIPHER_BUSY_O; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_busy_min; $rose(CIPHER_BUSY_O) |-> CIPHER_BUSY_O [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_busy_max; $rose(CIPHER_BUSY_O) |-> ##[218:298] !CIPHER_BUSY_O; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
endmodule // cis_top_chk

// file: verif/cis_fw_model.sv
// firmware or dma writer model for the staging registers
`timescale 1ns/1ps
module cis_fw_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [3:0] page_o = 4'h0,
  output logic [7:0] addr_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] wdata_o = 8'h00
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    page_o <= 4'h2;
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    page_o <= 4'h0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i);
    page_o <= 4'h2;
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    page_o <= 4'h0;
    addr_o <= ~a;
    @(negedge clk_i);
    q = rdata_i;
  endtask
  task automatic trip(input logic [7:0] b, input logic [7:0] x, input logic [7:0] k);
    wr(8'heb, b);
    wr(8'hec, x);
    wr(8'hed, k);
  endtask
endmodule // cis_fw_model

// file: verif/cipher_input_staging_bench.sv
// self-checking bench for the cipher input staging block
`timescale 1ns/1ps
module cipher_input_staging_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] page;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] q;
  logic wr;
  logic rd;
  logic [127:0] data;
  logic [127:0] xo;
  logic [255:0] key;
  logic enc;
  logic busy;
  logic done;
  int fails = 0;
  int n_checks = 0;
  logic [23:0] rows [5] = '{24'heba5a5, 24'hec5a5a, 24'hed3c3c, 24'hee7700, 24'he81100};
  always #2.5 clk = ~clk;
  cis_top cis_top_inst (.REF_CLK_I(clk), .ARST_N_I(arst_n), .SFR_PAGE_I(page), .SFR_ADDR_I(addr),
    .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .CIPHER_DATA_O(data),
    .CIPHER_KEY_O(key), .CIPHER_XOR_O(xo), .CIPHER_ENC_O(enc), .CIPHER_START_O(), .CIPHER_BUSY_O(busy),
    .CIPHER_DONE_O(done));
  cis_fw_model cis_fw_model_inst (.clk_i(clk), .rdata_i(rdata), .page_o(page), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata));
  task automatic chk(input string nm, input logic [255:0] got, input logic [255:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic run(input logic [7:0] cfg, input logic xen, input logic [7:0] x, input int nk, input int cyc);
    logic [127:0] ed;
    logic [127:0] ex;
    logic [255:0] ek;
    int nb;
    ed = '0;
    ex = '0;
    ek = '0;
    nb = 0;
    cis_fw_model_inst.wr(8'he9, cfg);
    @(negedge clk);
    chk("done clr", done, 1'b0);
    cis_fw_model_inst.wr(8'hea, {7'h00, xen});
    cis_fw_model_inst.wr(8'hec, x);
    for (int i = 0; i < nk; i++) begin
      ek[8*i+:8] = 8'h40 + 8'(nk + i);
      if (i < 16) begin
        ex[8*i+:8] = x + 8'(3 * i);
        ed[8*i+:8] = xen ? (8'(i + nk) ^ ex[8*i+:8]) : 8'(i + nk);
        cis_fw_model_inst.trip(8'(i + nk), ex[8*i+:8], ek[8*i+:8]);
      end else begin
        cis_fw_model_inst.wr(8'hed, ek[8*i+:8]);
      end
    end
    for (int j = 0; j < 400 && done !== 1'b1; j++) begin
      @(negedge clk);
      nb += int'(busy);
    end
    chk("done", done, 1'b1);
    if (done !== 1'b1) conclude();
    chk("busy cycles", nb, cyc);
    chk("enc", enc, cfg[2]);
    chk("data", data, ed);
    chk("xor", xo, ex);
    chk("key", key, ek);
    cis_fw_model_inst.rd(8'he9, q);
    chk("block cfg", q, {4'h2, cfg[3:0]});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int r = 0; r < 5; r++) begin
      cis_fw_model_inst.wr(rows[r][23:16], rows[r][15:8]);
      cis_fw_model_inst.rd(rows[r][23:16], q);
      chk("readback", q, rows[r][7:0]);
    end
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int r = 0; r < 3; r++) begin
      cis_fw_model_inst.rd(8'heb + 8'(r), q);
      chk("reset value", q, 8'h00);
    end
    run(8'h0c, 1'b1, 8'h5c, 16, int'(cis_pkg::CYC_128));
    run(8'h09, 1'b0, 8'h33, 24, int'(cis_pkg::CYC_192));
    run(8'h0a, 1'b1, 8'ha7, 32, int'(cis_pkg::CYC_256));
    conclude();
  end
endmodule // cipher_input_staging_bench
bind cis_top cis_top_chk cis_top_chk_inst (.REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .SFR_PAGE_I(SFR_PAGE_I),
  .SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I), .SFR_RDATA_O(SFR_RDATA_O),
  .CIPHER_START_O(CIPHER_START_O), .CIPHER_BUSY_O(CIPHER_BUSY_O), .CIPHER_DONE_O(CIPHER_DONE_O));
